// >>> hw/mcs_pkg.sv
/*
 * Package for the motor sampling / filter configuration block: register map,
 * field positions, reset values, timing steps and enumerations.
 * Assumes 8-bit register data and a 4 MHz nominal peripheral clock for times.
 */
package mcs_pkg;

    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 8;

    localparam logic [ADDR_W-1:0] ADDR_CFG  = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_PAR  = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_ZFR  = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_CTL  = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 3'h4;

    localparam logic [DATA_W-1:0] CFG_RST = 8'h02;
    localparam logic [DATA_W-1:0] PAR_RST = 8'h00;
    localparam logic [DATA_W-1:0] ZFR_RST = 8'h0f;
    localparam logic [DATA_W-1:0] CTL_RST = 8'h00;

    // sampling_and_clock_config
    localparam int unsigned CFG_DLY_LSB = 4;
    localparam int unsigned CFG_SOI_BIT = 3;
    localparam int unsigned CFG_SOM_BIT = 2;
    localparam int unsigned CFG_DIV_LSB = 0;
    // tacho_edge_and_output_parity
    localparam int unsigned PAR_TES_LSB = 6;
    localparam int unsigned NUM_CH      = 6;
    // z_event_filter_setup
    localparam int unsigned ZFR_ZEF_LSB = 4;
    localparam int unsigned ZFR_ZWF_LSB = 0;
    // own control register
    localparam int unsigned CTL_SR_BIT  = 0;
    localparam int unsigned CTL_PCN_BIT = 1;
    localparam int unsigned CTL_SZ_BIT  = 2;
    localparam int unsigned CTL_PWM_BIT = 3;
    localparam int unsigned CTL_SCF_LSB = 4;

    // times in ns at the nominal peripheral rate
    localparam int unsigned PERIPH_REF_MHZ  = 4;
    localparam int unsigned DELAY_STEP_NS   = 2500;
    localparam int unsigned WIN_LO_STEP_NS  = 5000;
    localparam int unsigned WIN_HI_BASE_NS  = 60000;
    localparam int unsigned WIN_HI_STEP_NS  = 20000;
    localparam int unsigned SCF_BASE_NS     = 1000;
    localparam int unsigned DELAY_STEP_TICKS = DELAY_STEP_NS * PERIPH_REF_MHZ / 1000;
    localparam int unsigned WIN_LO_TICKS     = WIN_LO_STEP_NS * PERIPH_REF_MHZ / 1000;
    localparam int unsigned WIN_HI_BASE_TICKS = WIN_HI_BASE_NS * PERIPH_REF_MHZ / 1000;
    localparam int unsigned WIN_HI_STEP_TICKS = WIN_HI_STEP_NS * PERIPH_REF_MHZ / 1000;
    localparam int unsigned SCF_BASE_TICKS   = SCF_BASE_NS * PERIPH_REF_MHZ / 1000;

    typedef enum logic [1:0] {
        MCS_DIV_1  = 2'b00,
        MCS_DIV_2  = 2'b01,
        MCS_DIV_4  = 2'b10,
        MCS_DIV_4B = 2'b11
    } mcs_div_t;

    typedef enum logic [1:0] {
        MCS_TES_POS  = 2'b00,
        MCS_TES_RISE = 2'b01,
        MCS_TES_FALL = 2'b10,
        MCS_TES_BOTH = 2'b11
    } mcs_tes_t;

    typedef enum logic [0:0] {
        MCS_SMP_IDLE = 1'b0,
        MCS_SMP_WAIT = 1'b1
    } mcs_smp_t;

endpackage

// >>> hw/mcs_top.sv
/*
 * Motor sampling, prescaler, parity and Z event filter logic with register port.
 * Assumes ref_clk_i is the motor-control clock, pwm_on_i and d_event_i come from
 * logic on the same clock, zc_raw_i comes from a comparator pin.
 */
// Design decisions made here: the register addresses and strobed register access.
// Summary of operation
// - delay code sets ON-time sample delay
// - each code step adds 2.5 us
// - late sample discarded, pending flag set
// - mask bit enables sampling-out interrupt
// - flag only for Z, nonzero delay
// - clock select divides by 1, 2, 4
// - tacho edge field picks capture edges
// - parity bit zero high, one low
// - parity ignored with independent phases
// - Z event after code+1 consecutive samples
// - Z samples at sampling clock or PWM
// - D event starts Z blanking window
// - window table sensorless, none in sensor
// - sampling clock 1 MHz down to 125 kHz
`timescale 1ns/1ps
module mcs_top
    import mcs_pkg::*;
#(
    parameter int unsigned DLY_W = 8,
    parameter int unsigned WIN_W = 10,
    parameter int unsigned SCF_W = 6
) (
    input  wire logic              ref_clk_i,
    input  wire logic              rst_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [DATA_W-1:0] rdata_o,
    input  wire logic              pwm_on_i,
    input  wire logic              d_event_i,
    input  wire logic              zc_raw_i,
    output logic                   periph_tick_o,
    output logic                   z_sample_o,
    output logic                   z_event_o,
    output logic                   blank_active_o,
    output logic                   speed_mode_o,
    output logic                   capture_rise_o,
    output logic                   capture_fall_o,
    output logic      [NUM_CH-1:0] out_level_o,
    output logic                   irq_o
);

    logic [DATA_W-1:0] cfg_q;
    logic [DATA_W-1:0] par_q;
    logic [DATA_W-1:0] zfr_q;
    logic [DATA_W-1:0] ctl_q;
    logic [DATA_W-1:0] rdata_q;
    logic              soi_q;
    logic [1:0]        div_cnt_q;
    logic [SCF_W-1:0]  scf_cnt_q;
    logic [DLY_W-1:0]  dly_cnt_q;
    mcs_smp_t          smp_q;
    logic              pwm_prev_q;
    logic [WIN_W-1:0]  win_cnt_q;
    logic [4:0]        zcnt_q;
    logic              zev_q;
    logic              zev_pls_q;
    logic              zsmp_q;
    logic              zc_s1_q;
    logic              zc_s2_q;
    logic              zc_s3_q;
    logic              zc_q;
    logic [NUM_CH-1:0] lvl_q;

    // field decode
    wire logic [3:0] ds_code  = cfg_q[CFG_DLY_LSB +: 4];
    wire logic       sampling_out_irq_mask      = cfg_q[CFG_SOM_BIT];
    wire mcs_div_t   div_sel  = mcs_div_t'(cfg_q[CFG_DIV_LSB +: 2]);
    wire mcs_tes_t   tes      = mcs_tes_t'(par_q[PAR_TES_LSB +: 2]);
    wire logic [3:0] zef      = zfr_q[ZFR_ZEF_LSB +: 4];
    wire logic [3:0] zwf      = zfr_q[ZFR_ZWF_LSB +: 4];
    wire logic       sensor   = ctl_q[CTL_SR_BIT];
    wire logic       independent_phase_config      = ctl_q[CTL_PCN_BIT];
    wire logic       at_pwm   = ctl_q[CTL_PWM_BIT];
    wire logic [1:0] scf      = ctl_q[CTL_SCF_LSB +: 2];

    wire logic wr_cfg = wr_i && (addr_i == ADDR_CFG);
    wire logic wr_par = wr_i && (addr_i == ADDR_PAR);
    wire logic wr_zfr = wr_i && (addr_i == ADDR_ZFR);
    wire logic wr_ctl = wr_i && (addr_i == ADDR_CTL);

    // peripheral clock enable
    logic tick;
    always_comb begin
        case (div_sel)
            MCS_DIV_1: tick = 1'b1;
            MCS_DIV_2: tick = div_cnt_q[0];
            default:   tick = &div_cnt_q;
        endcase
    end

    // sampling clock: base period doubled per select step
    wire logic [SCF_W-1:0] scf_period = SCF_W'(SCF_BASE_TICKS) << scf;
    // at-or-above: a shorter period picked mid-count ends at once, not after a wrap
    wire logic scf_tick = tick && (scf_cnt_q >= scf_period - SCF_W'(1));

    // ON-time sample delay
    wire logic [DLY_W-1:0] dly_ticks = DLY_W'(ds_code) * DLY_W'(DELAY_STEP_TICKS);
    wire logic pwm_rise   = pwm_on_i && !pwm_prev_q;
    wire logic pwm_fall   = !pwm_on_i && pwm_prev_q;
    wire logic dly_done   = (smp_q == MCS_SMP_WAIT) && tick && (dly_cnt_q == DLY_W'(1));
    // a sample that ripens after the ON time has closed is thrown away
    wire logic late_smp   = dly_done && !pwm_on_i && at_pwm && (ds_code != 4'h0);
    wire logic pwm_smp    = (ds_code == 4'h0) ? pwm_fall : (dly_done && pwm_on_i);
    wire logic zsmp_evt   = at_pwm ? pwm_smp : scf_tick;

    // blanking window length
    wire logic [WIN_W-1:0] win_lo = WIN_W'(WIN_LO_TICKS) * (WIN_W'(zwf[2:0]) + WIN_W'(1));
    wire logic [WIN_W-1:0] win_hi = WIN_W'(WIN_HI_BASE_TICKS) + WIN_W'(WIN_HI_STEP_TICKS) * WIN_W'(zwf[2:0]);
    wire logic [WIN_W-1:0] win_ticks = zwf[3] ? win_hi : win_lo;
    wire logic blanking = (win_cnt_q != '0);

    wire logic [4:0] z_need  = 5'(zef) + 5'h01;
    wire logic       z_take  = zsmp_evt && !blanking && !d_event_i;
    // at-or-above so lowering the code mid-count still fires
    wire logic       z_hit   = z_take && zc_q && !zev_q && (zcnt_q + 5'h01 >= z_need);

    wire logic [DATA_W-1:0] cfg_rd = {cfg_q[7:4], soi_q, cfg_q[2:0]};
    wire logic [DATA_W-1:0] stat_rd = {blanking, zev_q, zc_q, zcnt_q};
    logic [DATA_W-1:0] rd_mux;
    always_comb begin
        if (addr_i == ADDR_CFG) begin
            rd_mux = cfg_rd;
        end else if (addr_i == ADDR_PAR) begin
            rd_mux = par_q;
        end else if (addr_i == ADDR_ZFR) begin
            rd_mux = zfr_q;
        end else if (addr_i == ADDR_CTL) begin
            rd_mux = ctl_q;
        end else if (addr_i == ADDR_STAT) begin
            rd_mux = stat_rd;
        end else begin
            rd_mux = '0;
        end
    end

    // registers
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cfg_q <= CFG_RST;
            par_q <= PAR_RST;
            zfr_q <= ZFR_RST;
            ctl_q <= CTL_RST;
            rdata_q <= '0;
        end else begin
            if (wr_cfg) cfg_q <= wdata_i;
            if (wr_par) par_q <= wdata_i;
            if (wr_zfr) zfr_q <= wdata_i;
            if (wr_ctl) ctl_q <= wdata_i;
            rdata_q <= rd_i ? rd_mux : '0;
        end
    end

    // pending flag: set wins over a write-one clear
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            soi_q <= 1'b0;
        end else if (late_smp) begin
            soi_q <= 1'b1;
        end else if (wr_cfg && wdata_i[CFG_SOI_BIT]) begin
            soi_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            div_cnt_q <= '0;
            scf_cnt_q <= '0;
        end else begin
            div_cnt_q <= (div_sel == MCS_DIV_1) ? 2'h0 : div_cnt_q + 2'h1;
            if (scf_tick) begin
                scf_cnt_q <= '0;
            end else if (tick) begin
                scf_cnt_q <= scf_cnt_q + SCF_W'(1);
            end
        end
    end

    // delayed sample launcher; one sample per ON edge, edges while waiting are ignored
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            smp_q <= MCS_SMP_IDLE;
            dly_cnt_q <= '0;
            pwm_prev_q <= 1'b0;
        end else begin
            pwm_prev_q <= pwm_on_i;
            case (smp_q)
                MCS_SMP_IDLE: begin
                    if (pwm_rise && ds_code != 4'h0) begin
                        smp_q <= MCS_SMP_WAIT;
                        dly_cnt_q <= dly_ticks;
                    end
                end
                default: begin
                    if (dly_done || ds_code == 4'h0) begin
                        smp_q <= MCS_SMP_IDLE;
                    end else if (tick) begin
                        dly_cnt_q <= dly_cnt_q - DLY_W'(1);
                    end
                end
            endcase
        end
    end

    // comparator pin: three stages, accepted once stages two and three agree
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            zc_s1_q <= 1'b0;
            zc_s2_q <= 1'b0;
            zc_s3_q <= 1'b0;
            zc_q <= 1'b0;
        end else begin
            zc_s1_q <= zc_raw_i;
            zc_s2_q <= zc_s1_q;
            zc_s3_q <= zc_s2_q;
            if (zc_s2_q == zc_s3_q) zc_q <= zc_s3_q;
        end
    end

    // blanking and consecutive-sample filter
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            win_cnt_q <= '0;
            zcnt_q <= '0;
            zev_q <= 1'b0;
            zsmp_q <= 1'b0;
            zev_pls_q <= 1'b0;
        end else begin
            zsmp_q <= z_take;
            zev_pls_q <= z_hit;
            if (d_event_i) begin
                win_cnt_q <= sensor ? '0 : win_ticks;
                zcnt_q <= '0;
                zev_q <= 1'b0;
            end else begin
                if (blanking && tick) win_cnt_q <= win_cnt_q - WIN_W'(1);
                if (z_take) begin
                    if (!zc_q) begin
                        zcnt_q <= '0;
                    end else if (!zev_q) begin
                        zcnt_q <= zcnt_q + 5'h01;
                    end
                end
                if (z_hit) zev_q <= 1'b1;
            end
        end
    end

    // channel levels: zero drives high, parity ignored with independent phases
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            lvl_q <= '0;
        end else begin
            lvl_q <= independent_phase_config ? '0 : ~par_q[NUM_CH-1:0];
        end
    end

    assign rdata_o        = rdata_q;
    assign periph_tick_o  = tick;
    assign z_sample_o     = zsmp_q;
    assign z_event_o      = zev_pls_q;
    assign blank_active_o = blanking;
    assign speed_mode_o   = (tes != MCS_TES_POS);
    assign capture_rise_o = tes[0];
    assign capture_fall_o = tes[1];
    assign out_level_o    = lvl_q;
    assign irq_o          = soi_q && sampling_out_irq_mask;

    // assertions
    sequence s_div4_gap;
        (!tick || !div_sel[1]) [*3];
    endsequence

    AST_SOI_SET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        late_smp |=> soi_q)
        else $error("late sample did not set pending flag");

    AST_SOI_HOLD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        soi_q && !(wr_cfg && wdata_i[CFG_SOI_BIT]) |=> soi_q)
        else $error("pending flag dropped without clear");

    AST_IRQ_GATE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(irq_o) |-> soi_q && cfg_q[CFG_SOM_BIT])
        else $error("interrupt without flag and mask");

    AST_SOI_CAUSE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(soi_q) |-> $past(ds_code) != 4'h0 && $past(at_pwm))
        else $error("pending flag set without delay or pwm sampling");

    AST_DIV4: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        div_sel[1] && tick && $stable(div_sel) |=> s_div4_gap)
        else $error("divide by four ticks too often");

    AST_PARITY: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        wr_par && !independent_phase_config && !wr_ctl |=> ##1 out_level_o == ~$past(wdata_i[NUM_CH-1:0], 2))
        else $error("channel level not inverse of parity");

    AST_BLANK: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        d_event_i && !sensor |=> blank_active_o && !z_event_o)
        else $error("D event did not open blanking window");

    AST_NO_WIN: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        d_event_i && sensor |=> !blank_active_o)
        else $error("window applied in sensor mode");

    AST_ZEF1: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        z_take && zc_q && zef == 4'h0 && !zev_q && !wr_zfr |=> z_event_o)
        else $error("single sample filter did not fire");

    AST_IRQ_RAISE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        late_smp && sampling_out_irq_mask && !wr_cfg |=> irq_o)
        else $error("unmasked late sample gave no interrupt");

    AST_ZEV_ONE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        z_event_o |=> !z_event_o)
        else $error("Z event longer than one cycle");

    AST_PCN_LOW: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        independent_phase_config |=> out_level_o == '0)
        else $error("parity applied with independent phases");

    AST_NO_DLY: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        ds_code == 4'h0 |=> smp_q == MCS_SMP_IDLE)
        else $error("delay armed with zero delay code");

    AST_DLY_LOAD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        smp_q == MCS_SMP_IDLE && pwm_rise && ds_code != 4'h0 |=>
            dly_cnt_q == DLY_W'($past(ds_code) * DELAY_STEP_TICKS))
        else $error("sample delay not a whole number of steps");

    AST_TES_POS: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        tes == MCS_TES_POS |-> !speed_mode_o && !capture_rise_o && !capture_fall_o)
        else $error("speed capture enabled in position mode");

    AST_BLANK_QUIET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        blank_active_o |=> !z_sample_o)
        else $error("Z sample taken inside blanking window");

endmodule

// >>> tb/mcs_motor_model.sv
/*
 * Motor-side stand-in: PWM ON level, D event pulses and comparator level.
 * Assumes the block's clock; the ON length is taken once per 40-cycle period.
 */
`timescale 1ns/1ps
module mcs_motor_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [5:0] on_len_i,
    input  wire logic       d_req_i,
    input  wire logic       zc_lvl_i,
    output logic            pwm_on_o,
    output logic            d_event_o,
    output logic            zc_o
);
    logic [5:0] cnt_q;
    logic [5:0] len_q;
    logic       d_q;
    // length latched per period so a stop never truncates an ON pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 6'h00;
            len_q <= 6'h00;
            d_q   <= 1'b0;
        end else begin
            cnt_q <= (cnt_q == 6'h27) ? 6'h00 : cnt_q + 6'h01;
            len_q <= (cnt_q == 6'h27) ? on_len_i : len_q;
            d_q   <= d_req_i;
        end
    end
    assign pwm_on_o  = !rst_i && (cnt_q < len_q);
    assign d_event_o = !rst_i && d_q;
    assign zc_o      = zc_lvl_i;
endmodule

// >>> tb/mcs_top_tb_top.sv
/*
 * Self-checking bench for mcs_top: register port, prescaler, tacho and parity
 * decode, Z filter with blanking, sampling clock, sampling-out flag and irq.
 * Assumes the motor model on the far side and one 50 MHz clock.
 */
`timescale 1ns/1ps
module mcs_top_tb_top
    import mcs_pkg::*;
;
    logic              clk        = 1'b0;
    logic              rst        = 1'b1;
    logic [ADDR_W-1:0] addr       = '0;
    logic [DATA_W-1:0] wdata      = '0;
    logic              wr         = 1'b0;
    logic              rd         = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic              pwm_on;
    logic              d_event;
    logic              zc_raw;
    logic              tick;
    logic              zs;
    logic              ze;
    logic              blank;
    logic              spd;
    logic              crise;
    logic              cfall;
    logic [NUM_CH-1:0] lvl;
    logic              irq;
    logic [5:0]        on_len     = 6'h00;
    logic              d_req      = 1'b0;
    logic              zc_lvl     = 1'b0;
    int                err_total  = 0;
    int                num_checks = 0;
    int                gap;
    int                nt;
    logic [3:0]        so_ds [5]  = '{4'h1, 4'h1, 4'h3, 4'h3, 4'h0};
    logic [5:0]        so_on [5]  = '{6'h04, 6'h0e, 6'h1a, 6'h22, 6'h04};
    logic              so_p  [5]  = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

    always #10 clk = ~clk;

    mcs_top DUT (
        .ref_clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .pwm_on_i(pwm_on), .d_event_i(d_event), .zc_raw_i(zc_raw),
        .periph_tick_o(tick), .z_sample_o(zs), .z_event_o(ze), .blank_active_o(blank),
        .speed_mode_o(spd), .capture_rise_o(crise), .capture_fall_o(cfall),
        .out_level_o(lvl), .irq_o(irq)
    );

    mcs_motor_model u_motor (
        .clk_i(clk), .rst_i(rst), .on_len_i(on_len), .d_req_i(d_req), .zc_lvl_i(zc_lvl),
        .pwm_on_o(pwm_on), .d_event_o(d_event), .zc_o(zc_raw)
    );

    task automatic print_verdict();
        if (err_total == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic bail();
        err_total++;
        print_verdict();
    endtask

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic rd_chk(input string nm, input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk(nm, rdata, exp);
    endtask

    // pwm stopped before returning so the flag is stable when read
    task automatic run_pwm(input logic [5:0] len);
        on_len <= len;
        repeat (120) @(posedge clk);
        on_len <= 6'h00;
        repeat (50) @(posedge clk);
    endtask

    task automatic z_run(input logic [3:0] zef, input logic [3:0] zwf, input logic sr, input int exp_b);
        int nb;
        int ns;
        int k;
        nb = 0;
        ns = 0;
        k  = 0;
        wr_reg(ADDR_CTL, {7'h00, sr});
        wr_reg(ADDR_ZFR, {zef, zwf});
        @(posedge clk);
        d_req <= 1'b1;
        @(posedge clk);
        d_req <= 1'b0;
        @(posedge clk);
        // look only after the D edge: a pulse counted before it must not end the wait
        do begin
            @(negedge clk);
            k++;
            nb += (blank === 1'b1);
            ns += (zs === 1'b1 && blank !== 1'b1);
        end while (ze !== 1'b1 && k < 1200);
        if (k >= 1200) bail();
        chk("blank_len", {7'h00, nb >= exp_b && nb <= exp_b + 1}, 8'h01);
        chk("z_samples", 8'(ns), {4'h0, zef} + 8'h01);
        rd_chk("z_status", ADDR_STAT, {3'b011, 5'(zef) + 5'h01});
    endtask

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd_chk("cfg_rst", ADDR_CFG, CFG_RST);
        rd_chk("par_rst", ADDR_PAR, PAR_RST);
        rd_chk("zfr_rst", ADDR_ZFR, ZFR_RST);
        rd_chk("ctl_rst", ADDR_CTL, CTL_RST);
        @(posedge clk);
        #1;
        chk("rdata_idle", rdata, 8'h00);
        wr_reg(3'h5, 8'hff);
        rd_chk("unmapped", 3'h5, 8'h00);
        for (int d = 0; d < 4; d++) begin
            wr_reg(ADDR_CFG, 8'(d));
            nt = 0;
            repeat (40) begin
                @(negedge clk);
                nt += (tick === 1'b1);
            end
            chk("tick_cnt", 8'(nt), (d == 0) ? 8'h28 : (d == 1) ? 8'h14 : 8'h0a);
        end
        for (int t = 0; t < 4; t++) begin
            wr_reg(ADDR_PAR, {t[1:0], 6'h2a});
            @(negedge clk);
            chk("tacho", {5'h00, spd, crise, cfall}, {5'h00, t != 0, t[0], t[1]});
        end
        @(negedge clk);
        chk("out_level", {2'h0, lvl}, 8'h15);
        wr_reg(ADDR_CTL, 8'h02);
        repeat (2) @(negedge clk);
        chk("out_pcn", {2'h0, lvl}, 8'h00);
        // fastest prescale keeps the long windows short in cycles
        wr_reg(ADDR_CFG, 8'h00);
        zc_lvl <= 1'b1;
        z_run(4'h0, 4'h0, 1'b0, 20);
        z_run(4'h3, 4'h7, 1'b0, 160);
        z_run(4'hf, 4'h8, 1'b0, 240);
        z_run(4'h1, 4'hf, 1'b0, 800);
        z_run(4'h2, 4'h7, 1'b1, 0);
        for (int s = 0; s < 4; s++) begin
            wr_reg(ADDR_CTL, {2'b00, s[1:0], 4'h0});
            for (int k = 0; k < 3; k++) begin
                gap = 0;
                do begin
                    @(negedge clk);
                    gap++;
                end while (zs !== 1'b1 && gap < 100);
            end
            if (gap >= 100) bail();
            chk("scf_gap", 8'(gap), 8'h04 << s);
        end
        wr_reg(ADDR_CTL, 8'h08);
        for (int i = 0; i < 5; i++) begin
            wr_reg(ADDR_CFG, {so_ds[i], 4'hc});
            run_pwm(so_on[i]);
            rd_chk("soi", ADDR_CFG, {so_ds[i], so_p[i], 3'h4});
            chk("irq", {7'h00, irq}, {7'h00, so_p[i]});
        end
        wr_reg(ADDR_CFG, 8'h18);
        run_pwm(6'h04);
        rd_chk("soi_sticky", ADDR_CFG, 8'h18);
        chk("irq_masked", {7'h00, irq}, 8'h00);
        wr_reg(ADDR_CFG, 8'h14);
        repeat (2) @(negedge clk);
        chk("irq_unmasked", {7'h00, irq}, 8'h01);
        print_verdict();
    end
endmodule
